// *** common/jmc_pkg.sv ***
// shared constants, register map and carrier types of the jog motion controller
package jmc_pkg;

  localparam int JMC_VEL_W = 16;
  localparam int JMC_POS_W = 32;
  localparam int JMC_OVR_W = 8;
  localparam int JMC_IRQ_W = 4;

  localparam int CLK_PERIOD_NS = 5;
  localparam int RAMP_PERIOD_NS = 1000;
  localparam int RAMP_TICK_CYCLES = (RAMP_PERIOD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  localparam logic [11:0] JMC_CTRL_OFFSET = 12'h000;
  localparam logic [11:0] JMC_JOG_ONE_VELOCITY_SETPOINT_OFFSET = 12'h004;
  localparam logic [11:0] JMC_JOG_TWO_VELOCITY_SETPOINT_OFFSET = 12'h008;
  localparam logic [11:0] JMC_JOG_ONE_INCREMENT_OFFSET = 12'h00C;
  localparam logic [11:0] JMC_JOG_TWO_INCREMENT_OFFSET = 12'h010;
  localparam logic [11:0] JMC_OVERRIDE_OFFSET = 12'h014;
  localparam logic [11:0] JMC_MAX_DECELERATION_SETTING_OFFSET = 12'h018;
  localparam logic [11:0] JMC_LIMIT_POS_OFFSET = 12'h01C;
  localparam logic [11:0] JMC_LIMIT_NEG_OFFSET = 12'h020;
  localparam logic [11:0] JMC_STATUS_OFFSET = 12'h024;
  localparam logic [11:0] JMC_IRQ_STATUS_OFFSET = 12'h028;
  localparam logic [11:0] JMC_IRQ_MASK_OFFSET = 12'h02C;
  localparam logic [11:0] JMC_SPEED_OFFSET = 12'h030;

  localparam int JMC_CTRL_POS_MODE = 0;
  localparam int JMC_CTRL_JOG_ONE = 1;
  localparam int JMC_CTRL_JOG_TWO = 2;
  localparam int JMC_CTRL_INC_SELECT = 3;
  localparam int JMC_CTRL_INVERT_A = 4;
  localparam int JMC_CTRL_INVERT_B = 5;
  localparam int JMC_CTRL_LIMIT_ENABLE = 6;
  localparam int JMC_CTRL_LIMIT_SET = 7;
  localparam int JMC_CTRL_REFERENCED = 8;
  localparam int JMC_CTRL_W = 9;

  localparam int JMC_IRQ_FAULT = 0;
  localparam int JMC_IRQ_LIMIT = 1;
  localparam int JMC_IRQ_INC_DONE = 2;
  localparam int JMC_IRQ_STOPPED = 3;

  localparam logic [JMC_CTRL_W-1:0] JMC_CTRL_RESET = 9'h001;
  localparam logic [JMC_VEL_W-1:0] JMC_VEL_RESET = 16'h0000;
  localparam logic [JMC_POS_W-1:0] JMC_POS_RESET = 32'h0000_0000;
  localparam logic [JMC_OVR_W-1:0] JMC_OVERRIDE_RESET = 8'hFF;
  localparam logic [JMC_VEL_W-1:0] JMC_DECEL_RESET = 16'h0010;
  localparam logic [JMC_IRQ_W-1:0] JMC_IRQ_RESET = 4'h0;

  typedef enum logic [2:0] {
    JMC_IDLE = 3'b000,
    JMC_RUN = 3'b001,
    JMC_BRAKE = 3'b011,
    JMC_DONE = 3'b010,
    JMC_FAULT = 3'b110
  } jmc_fsm_type;

  typedef struct packed {
    logic hsel;
    logic [31:0] haddr;
    logic [1:0] htrans;
    logic hwrite;
    logic [2:0] hsize;
    logic [31:0] hwdata;
    logic hready;
  } jmc_ahb_in_type;

  typedef struct packed {
    logic [31:0] hrdata;
    logic hreadyout;
    logic hresp;
  } jmc_ahb_out_type;

  typedef struct packed {
    logic jogOne;
    logic jogTwo;
    logic incSelect;
  } jmc_jog_pins_type;

endpackage

// *** core/jmc_sync.sv ***
// two-stage synchroniser for the jog terminal inputs
module jmc_sync
  import jmc_pkg::*;
#(
  parameter int WIDTH = 3
) (
  input wire logic sys_clk,
  input wire logic reset,
  input wire logic [WIDTH-1:0] asyncIn,
  output logic [WIDTH-1:0] syncOut
);

  typedef struct packed {
    logic [WIDTH-1:0] meta;
    logic [WIDTH-1:0] stable;
  } jmc_sync_state_type;

  jmc_sync_state_type r;
  jmc_sync_state_type next_r;

  // meta feeds only the second stage
  always_comb begin
    next_r.meta = asyncIn;
    next_r.stable = r.meta;
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      r <= '0;
    end else begin
      r <= next_r;
    end
  end

  assign syncOut = r.stable;

endmodule

// *** core/jmc_ramp.sv ***
// speed ramp: moves the setpoint toward the target by the deceleration step per tick
module jmc_ramp
  import jmc_pkg::*;
#(
  parameter int TICK_CYCLES = RAMP_TICK_CYCLES
) (
  input wire logic sys_clk,
  input wire logic reset,
  input wire logic signed [JMC_VEL_W-1:0] target,
  input wire logic [JMC_VEL_W-1:0] step,
  input wire logic stopNow,
  output logic signed [JMC_VEL_W-1:0] speed
);

  typedef struct packed {
    logic [15:0] count;
    logic signed [JMC_VEL_W-1:0] speed;
  } jmc_ramp_state_type;

  jmc_ramp_state_type r;
  jmc_ramp_state_type next_r;
  logic tick;
  logic signed [JMC_VEL_W:0] diff;
  logic signed [JMC_VEL_W:0] stepWide;

  always_comb begin
    next_r = r;
    tick = (r.count == 16'(TICK_CYCLES - 1));
    next_r.count = tick ? 16'h0000 : r.count + 16'h0001;
    diff = target - r.speed;
    stepWide = $signed({1'b0, step});
    if (stopNow) begin
      next_r.speed = '0;
    end else if (tick) begin
      // step bounds both acceleration and braking, so the overrun at a limit follows it
      if (diff > stepWide) begin
        next_r.speed = r.speed + JMC_VEL_W'(stepWide);
      end else if (diff < -stepWide) begin
        next_r.speed = r.speed - JMC_VEL_W'(stepWide);
      end else begin
        next_r.speed = target;
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      r <= '0;
    end else begin
      r <= next_r;
    end
  end

  assign speed = r.speed;

  a_stop_zeroes_speed: assert property (@(posedge sys_clk) disable iff (reset)
    stopNow |=> speed == 0)
    else $error("speed not zero after stop");

  a_brake_step_size: assert property (@(posedge sys_clk) disable iff (reset)
    (!stopNow && tick && target == 0 && r.speed > $signed({1'b0, step}))
      |=> speed == $past(r.speed) - $signed({1'b0, $past(step)}))
    else $error("braking step does not match deceleration");

endmodule

// *** core/jmc_jog_motion_control.sv ***
// jog motion controller with AHB-Lite register slave
module jmc_jog_motion_control
  import jmc_pkg::*;
#(
  parameter int TICK_CYCLES = RAMP_TICK_CYCLES
) (
  input wire logic sys_clk,
  input wire logic reset,
  input wire jmc_ahb_in_type ahbIn,
  output jmc_ahb_out_type ahbOut,
  input wire jmc_jog_pins_type jogPins,
  input wire logic signed [JMC_POS_W-1:0] actualPosition,
  input wire logic signed [JMC_VEL_W-1:0] speedActual,
  output logic signed [JMC_VEL_W-1:0] speedSetpoint,
  output logic signed [JMC_VEL_W-1:0] posVelActual,
  output logic trackingActive,
  output logic jogFault,
  output logic irq
);

  typedef struct packed {
    jmc_fsm_type fsm;
    logic channel;
    logic incMode;
    logic signed [JMC_POS_W-1:0] goal;
    logic wrPend;
    logic [11:0] wrAddr;
    jmc_ahb_out_type ahbOut;
    logic [JMC_CTRL_W-1:0] ctrl;
    logic signed [JMC_VEL_W-1:0] jogOneVelocitySetpoint;
    logic signed [JMC_VEL_W-1:0] jogTwoVelocitySetpoint;
    logic [JMC_POS_W-1:0] jogOneIncrement;
    logic [JMC_POS_W-1:0] jogTwoIncrement;
    logic [JMC_OVR_W-1:0] override;
    logic [JMC_VEL_W-1:0] maxDecelerationSetting;
    logic signed [JMC_POS_W-1:0] limitPos;
    logic signed [JMC_POS_W-1:0] limitNeg;
    logic [JMC_IRQ_W-1:0] irqStatus;
    logic [JMC_IRQ_W-1:0] irqMask;
    logic signed [JMC_VEL_W-1:0] target;
    logic stopNow;
    logic tracking;
    logic fault;
    logic irqOut;
    logic signed [JMC_VEL_W-1:0] velActual;
  } jmc_top_state_type;

  jmc_top_state_type r;
  jmc_top_state_type next_r;
  jmc_jog_pins_type pinSync;
  logic signed [JMC_VEL_W-1:0] rampSpeed;

  logic reqOne;
  logic reqTwo;
  logic reqBoth;
  logic reqActive;
  logic incSelect;
  logic posMode;
  logic chanSel;
  logic signed [JMC_VEL_W-1:0] velSel;
  logic [JMC_POS_W-1:0] incSel;
  logic signed [24:0] product;
  logic signed [JMC_VEL_W-1:0] scaled;
  logic signed [JMC_VEL_W-1:0] cmdVel;
  logic invert;
  logic dirPos;
  logic limitsActive;
  logic limitHit;
  logic goalHit;
  logic addrPhase;
  logic [JMC_IRQ_W-1:0] events;
  logic [JMC_IRQ_W-1:0] clearBits;

  // terminal inputs come from outside the clock domain
  jmc_sync #(
    .WIDTH(3)
  ) u_sync (
    .sys_clk(sys_clk),
    .reset(reset),
    .asyncIn(jogPins),
    .syncOut(pinSync)
  );

  jmc_ramp #(
    .TICK_CYCLES(TICK_CYCLES)
  ) u_ramp (
    .sys_clk(sys_clk),
    .reset(reset),
    .target(r.target),
    .step(r.maxDecelerationSetting),
    .stopNow(r.stopNow),
    .speed(rampSpeed)
  );

  function automatic logic [31:0] readReg(input logic [11:0] a, input jmc_top_state_type s,
                                          input logic signed [JMC_VEL_W-1:0] spd);
    logic [31:0] d;
    d = 32'h0000_0000;
    case (a)
      JMC_CTRL_OFFSET: d = 32'(s.ctrl);
      JMC_JOG_ONE_VELOCITY_SETPOINT_OFFSET: d = {16'h0000, s.jogOneVelocitySetpoint};
      JMC_JOG_TWO_VELOCITY_SETPOINT_OFFSET: d = {16'h0000, s.jogTwoVelocitySetpoint};
      JMC_JOG_ONE_INCREMENT_OFFSET: d = s.jogOneIncrement;
      JMC_JOG_TWO_INCREMENT_OFFSET: d = s.jogTwoIncrement;
      JMC_OVERRIDE_OFFSET: d = 32'(s.override);
      JMC_MAX_DECELERATION_SETTING_OFFSET: d = 32'(s.maxDecelerationSetting);
      JMC_LIMIT_POS_OFFSET: d = s.limitPos;
      JMC_LIMIT_NEG_OFFSET: d = s.limitNeg;
      JMC_STATUS_OFFSET: d = {25'h000_0000, s.incMode, s.channel, s.fault, s.tracking, s.fsm};
      JMC_IRQ_STATUS_OFFSET: d = 32'(s.irqStatus);
      JMC_IRQ_MASK_OFFSET: d = 32'(s.irqMask);
      JMC_SPEED_OFFSET: d = {16'h0000, spd};
      default: d = 32'h0000_0000;
    endcase
    return d;
  endfunction

  always_comb begin
    next_r = r;
    events = '0;
    clearBits = '0;

    posMode = r.ctrl[JMC_CTRL_POS_MODE];
    reqOne = pinSync.jogOne | r.ctrl[JMC_CTRL_JOG_ONE];
    reqTwo = pinSync.jogTwo | r.ctrl[JMC_CTRL_JOG_TWO];
    reqBoth = reqOne & reqTwo;
    incSelect = pinSync.incSelect | r.ctrl[JMC_CTRL_INC_SELECT];

    // in idle the channel comes from the live request, afterwards from the latched task
    chanSel = (r.fsm == JMC_IDLE) ? reqTwo : r.channel;
    reqActive = r.channel ? reqTwo : reqOne;
    velSel = chanSel ? r.jogTwoVelocitySetpoint : r.jogOneVelocitySetpoint;
    incSel = chanSel ? r.jogTwoIncrement : r.jogOneIncrement;

    // override of 255 is full scale, so the product can never exceed the setpoint
    product = velSel * $signed({1'b0, r.override});
    scaled = product[23:8];
    invert = r.ctrl[JMC_CTRL_INVERT_A] ^ r.ctrl[JMC_CTRL_INVERT_B];
    cmdVel = invert ? JMC_VEL_W'(-scaled) : scaled;
    dirPos = !velSel[JMC_VEL_W-1];

    limitsActive = r.ctrl[JMC_CTRL_LIMIT_ENABLE] & r.ctrl[JMC_CTRL_LIMIT_SET]
                   & r.ctrl[JMC_CTRL_REFERENCED];
    limitHit = limitsActive && (dirPos ? (actualPosition >= r.limitPos)
                                       : (actualPosition <= r.limitNeg));
    goalHit = dirPos ? (actualPosition >= r.goal) : (actualPosition <= r.goal);

    next_r.target = '0;
    next_r.stopNow = 1'b1;

    case (r.fsm)
      JMC_IDLE: begin
        if (reqBoth) begin
          next_r.fsm = JMC_FAULT;
          events[JMC_IRQ_FAULT] = 1'b1;
        end else if (posMode && (reqOne || reqTwo)) begin
          // every start takes a fresh goal, so an interrupted increment is never resumed
          next_r.fsm = JMC_RUN;
          next_r.channel = reqTwo;
          next_r.incMode = incSelect;
          next_r.goal = dirPos ? actualPosition + $signed(incSel)
                               : actualPosition - $signed(incSel);
        end
      end
      JMC_RUN: begin
        if (reqBoth) begin
          next_r.fsm = JMC_FAULT;
          events[JMC_IRQ_FAULT] = 1'b1;
        end else if (!reqActive || !posMode) begin
          next_r.fsm = JMC_IDLE;
          events[JMC_IRQ_STOPPED] = 1'b1;
        end else if (r.incMode && goalHit) begin
          next_r.fsm = JMC_DONE;
          events[JMC_IRQ_INC_DONE] = 1'b1;
        end else if (limitHit) begin
          next_r.fsm = JMC_BRAKE;
          next_r.stopNow = 1'b0;
          events[JMC_IRQ_LIMIT] = 1'b1;
        end else begin
          next_r.target = cmdVel;
          next_r.stopNow = 1'b0;
        end
      end
      JMC_BRAKE: begin
        next_r.stopNow = 1'b0;
        if (reqBoth) begin
          next_r.fsm = JMC_FAULT;
          next_r.stopNow = 1'b1;
          events[JMC_IRQ_FAULT] = 1'b1;
        end else if (!reqActive || !posMode) begin
          next_r.fsm = JMC_IDLE;
          next_r.stopNow = 1'b1;
          events[JMC_IRQ_STOPPED] = 1'b1;
        end else if (rampSpeed == 0) begin
          next_r.fsm = JMC_DONE;
        end
      end
      JMC_DONE: begin
        if (reqBoth) begin
          next_r.fsm = JMC_FAULT;
          events[JMC_IRQ_FAULT] = 1'b1;
        end else if (!reqActive) begin
          next_r.fsm = JMC_IDLE;
        end
      end
      JMC_FAULT: begin
        if (!reqOne && !reqTwo) begin
          next_r.fsm = JMC_IDLE;
        end
      end
      default: begin
        next_r.fsm = JMC_IDLE;
      end
    endcase

    next_r.tracking = (next_r.fsm == JMC_RUN) || (next_r.fsm == JMC_BRAKE);
    next_r.fault = (next_r.fsm == JMC_FAULT);
    next_r.velActual = speedActual;

    // data phase of a write taken in the previous cycle
    if (r.wrPend) begin
      case (r.wrAddr)
        JMC_CTRL_OFFSET: next_r.ctrl = ahbIn.hwdata[JMC_CTRL_W-1:0];
        JMC_JOG_ONE_VELOCITY_SETPOINT_OFFSET: next_r.jogOneVelocitySetpoint = ahbIn.hwdata[15:0];
        JMC_JOG_TWO_VELOCITY_SETPOINT_OFFSET: next_r.jogTwoVelocitySetpoint = ahbIn.hwdata[15:0];
        JMC_JOG_ONE_INCREMENT_OFFSET: next_r.jogOneIncrement = ahbIn.hwdata;
        JMC_JOG_TWO_INCREMENT_OFFSET: next_r.jogTwoIncrement = ahbIn.hwdata;
        JMC_OVERRIDE_OFFSET: next_r.override = ahbIn.hwdata[JMC_OVR_W-1:0];
        JMC_MAX_DECELERATION_SETTING_OFFSET: next_r.maxDecelerationSetting = ahbIn.hwdata[15:0];
        JMC_LIMIT_POS_OFFSET: next_r.limitPos = ahbIn.hwdata;
        JMC_LIMIT_NEG_OFFSET: next_r.limitNeg = ahbIn.hwdata;
        JMC_IRQ_STATUS_OFFSET: clearBits = ahbIn.hwdata[JMC_IRQ_W-1:0];
        JMC_IRQ_MASK_OFFSET: next_r.irqMask = ahbIn.hwdata[JMC_IRQ_W-1:0];
        default: next_r.wrPend = 1'b0;
      endcase
    end

    // a new event beats a clear in the same cycle
    next_r.irqStatus = (r.irqStatus & ~clearBits) | events;
    next_r.irqOut = |(next_r.irqStatus & next_r.irqMask);

    addrPhase = ahbIn.hsel && ahbIn.hready && ahbIn.htrans[1];
    next_r.wrPend = addrPhase && ahbIn.hwrite;
    if (addrPhase) begin
      next_r.wrAddr = {ahbIn.haddr[11:2], 2'b00};
    end
    if (addrPhase && !ahbIn.hwrite) begin
      next_r.ahbOut.hrdata = readReg({ahbIn.haddr[11:2], 2'b00}, r, rampSpeed);
    end
    // zero wait states, always OKAY
    next_r.ahbOut.hreadyout = 1'b1;
    next_r.ahbOut.hresp = 1'b0;
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      r <= '0;
      r.fsm <= JMC_IDLE;
      r.ahbOut.hreadyout <= 1'b1;
      r.ctrl <= JMC_CTRL_RESET;
      r.jogOneVelocitySetpoint <= JMC_VEL_RESET;
      r.jogTwoVelocitySetpoint <= JMC_VEL_RESET;
      r.jogOneIncrement <= JMC_POS_RESET;
      r.jogTwoIncrement <= JMC_POS_RESET;
      r.override <= JMC_OVERRIDE_RESET;
      r.maxDecelerationSetting <= JMC_DECEL_RESET;
      r.limitPos <= JMC_POS_RESET;
      r.limitNeg <= JMC_POS_RESET;
      r.irqStatus <= JMC_IRQ_RESET;
      r.irqMask <= JMC_IRQ_RESET;
      r.stopNow <= 1'b1;
    end else begin
      r <= next_r;
    end
  end

  assign ahbOut = r.ahbOut;
  assign speedSetpoint = rampSpeed;
  assign posVelActual = r.velActual;
  assign trackingActive = r.tracking;
  assign jogFault = r.fault;
  assign irq = r.irqOut;

  a_both_requests_fault: assert property (@(posedge sys_clk) disable iff (reset)
    (reqBoth && r.fsm != JMC_FAULT) |=> (r.fsm == JMC_FAULT) ##1 (jogFault && r.stopNow))
    else $error("simultaneous jog requests did not fault");

  a_release_stops_axis: assert property (@(posedge sys_clk) disable iff (reset)
    (r.fsm == JMC_RUN && !reqActive && !reqBoth) |=> (r.fsm == JMC_IDLE) ##1 (speedSetpoint == 0))
    else $error("axis still moving after jog release");

  a_start_on_request: assert property (@(posedge sys_clk) disable iff (reset)
    (r.fsm == JMC_IDLE && posMode && reqOne && !reqTwo) |=> (r.fsm == JMC_RUN && !r.channel))
    else $error("jog one request did not start channel one");

  a_mode_latched: assert property (@(posedge sys_clk) disable iff (reset)
    (r.fsm == JMC_IDLE && posMode && (reqOne ^ reqTwo)) |=> (r.incMode == $past(incSelect)))
    else $error("incremental selection not taken at start");

  a_direction_sign: assert property (@(posedge sys_clk) disable iff (reset)
    (r.fsm == JMC_RUN && reqActive && !reqBoth && posMode && !limitHit && !invert
     && !(r.incMode && goalHit) && scaled > 0) |=> r.target > 0)
    else $error("jog target sign differs from setpoint");

  a_invert_reverses: assert property (@(posedge sys_clk) disable iff (reset)
    (r.fsm == JMC_RUN && reqActive && !reqBoth && posMode && !limitHit && invert
     && !(r.incMode && goalHit) && scaled > 0) |=> r.target < 0)
    else $error("inverted reference did not reverse jog");

  a_override_zero: assert property (@(posedge sys_clk) disable iff (reset)
    (r.override == 0) |=> r.target == 0)
    else $error("zero override still commands speed");

  a_limit_needs_referenced: assert property (@(posedge sys_clk) disable iff (reset)
    (r.fsm == JMC_RUN && !limitsActive) |=> r.fsm != JMC_BRAKE)
    else $error("limit braking without active limits");

  a_limit_starts_brake: assert property (@(posedge sys_clk) disable iff (reset)
    (r.fsm == JMC_RUN && reqActive && !reqBoth && posMode && limitHit && !(r.incMode && goalHit))
      |=> (r.fsm == JMC_BRAKE && r.target == 0 && !r.stopNow))
    else $error("limit reached without braking");

  a_increment_done: assert property (@(posedge sys_clk) disable iff (reset)
    (r.fsm == JMC_DONE && !reqActive && !reqBoth) |=> r.fsm == JMC_IDLE)
    else $error("finished increment not discarded on release");

  a_tracking_in_jog: assert property (@(posedge sys_clk) disable iff (reset)
    (r.fsm == JMC_RUN) |-> (trackingActive && posVelActual == $past(speedActual)))
    else $error("jogging without tracking status");

endmodule

// *** verification/jmc_motor_model.sv ***
// behavioural motor and encoder behind the speed command
module jmc_motor_model
  import jmc_pkg::*;
(
  input wire logic sys_clk,
  input wire logic reset,
  input wire logic signed [JMC_VEL_W-1:0] speedSetpoint,
  output logic signed [JMC_VEL_W-1:0] speedActual,
  output logic signed [JMC_POS_W-1:0] actualPosition
);
  timeunit 1ns;
  timeprecision 1ps;
  // ideal speed loop: one cycle lag, so position integrates real motion
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      speedActual <= '0;
      actualPosition <= '0;
    end else begin
      speedActual <= speedSetpoint;
      actualPosition <= actualPosition + JMC_POS_W'(speedActual);
    end
  end
endmodule

// *** verification/jmc_jog_motion_control_tb.sv ***
// self-checking bench of the jog motion controller
module jmc_jog_motion_control_tb
  import jmc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int TICK = 4;
  logic sys_clk = 1'b0;
  logic reset = 1'b1;
  jmc_ahb_in_type bus = '0;
  jmc_ahb_in_type ahbIn;
  jmc_ahb_out_type ahbOut;
  jmc_jog_pins_type jogPins = '0;
  logic signed [JMC_VEL_W-1:0] speedActual;
  logic signed [JMC_VEL_W-1:0] speedSetpoint;
  logic signed [JMC_VEL_W-1:0] posVelActual;
  logic signed [JMC_POS_W-1:0] actualPosition;
  logic trackingActive;
  logic jogFault;
  logic irq;
  logic [31:0] rd;
  int failures = 0;
  int comparisons = 0;

  always_comb begin
    ahbIn = bus;
    ahbIn.hready = ahbOut.hreadyout;
  end

  jmc_jog_motion_control #(.TICK_CYCLES(TICK)) u_jmc_jog_motion_control (
    .sys_clk(sys_clk), .reset(reset), .ahbIn(ahbIn), .ahbOut(ahbOut), .jogPins(jogPins),
    .actualPosition(actualPosition), .speedActual(speedActual), .speedSetpoint(speedSetpoint),
    .posVelActual(posVelActual), .trackingActive(trackingActive), .jogFault(jogFault), .irq(irq)
  );

  jmc_motor_model u_jmc_motor_model (
    .sys_clk(sys_clk), .reset(reset), .speedSetpoint(speedSetpoint),
    .speedActual(speedActual), .actualPosition(actualPosition)
  );

  initial begin
    forever #2.5 sys_clk = ~sys_clk;
  end

  task automatic final_report;
    $display("comparisons %0d failures %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      failures++;
      $display("Error %s expected %h seen %h", name, exp, seen);
    end
  endtask

  // one single transfer; hready is sampled at each edge before moving on
  task automatic ahb(input logic isWrite, input logic [11:0] a, input logic [31:0] wd, output logic [31:0] d);
    bus.hsel <= 1'b1;
    bus.haddr <= {20'h0_0000, a};
    bus.htrans <= 2'h2;
    bus.hwrite <= isWrite;
    bus.hsize <= 3'h2;
    @(posedge sys_clk);
    while (ahbOut.hreadyout !== 1'b1) @(posedge sys_clk);
    bus.hsel <= 1'b0;
    bus.htrans <= 2'h0;
    bus.hwdata <= wd;
    @(posedge sys_clk);
    while (ahbOut.hreadyout !== 1'b1) @(posedge sys_clk);
    d = ahbOut.hrdata;
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] wd);
    logic [31:0] d;
    ahb(1'b1, a, wd, d);
  endtask

  task automatic rdchk(input string name, input logic [11:0] a, input logic [31:0] exp);
    ahb(1'b0, a, 32'h0000_0000, rd);
    check(name, rd, exp);
  endtask

  task automatic wait_speed(input string name, input logic [15:0] exp);
    int n;
    n = 0;
    while (speedSetpoint !== exp && n < 400) begin
      @(posedge sys_clk);
      n++;
    end
    check(name, {16'h0000, speedSetpoint}, {16'h0000, exp});
  endtask

  task automatic wait_irq(input int b);
    int n;
    n = 0;
    rd = 32'h0000_0000;
    while (rd[b] !== 1'b1 && n < 300) begin
      ahb(1'b0, JMC_IRQ_STATUS_OFFSET, 32'h0000_0000, rd);
      n++;
    end
  endtask

  // generous bound: the sequence needs roughly a thousand cycles
  initial begin
    repeat (40000) @(posedge sys_clk);
    failures++;
    final_report();
  end

  initial begin
    repeat (10) @(posedge sys_clk);
    reset <= 1'b0;
    @(posedge sys_clk);
    rdchk("ctrl reset", JMC_CTRL_OFFSET, 32'h0000_0001);
    rdchk("override reset", JMC_OVERRIDE_OFFSET, 32'h0000_00FF);
    rdchk("decel reset", JMC_MAX_DECELERATION_SETTING_OFFSET, 32'h0000_0010);
    rdchk("unmapped", 12'h040, 32'h0000_0000);
    check("hresp okay", {31'h0, ahbOut.hresp}, 32'h0);
    // multiples of 256 keep the override product exact
    wr(JMC_OVERRIDE_OFFSET, 32'h0000_0080);
    wr(JMC_JOG_ONE_VELOCITY_SETPOINT_OFFSET, 32'h0000_0200);
    wr(JMC_JOG_TWO_VELOCITY_SETPOINT_OFFSET, 32'h0000_FE00);
    wr(JMC_CTRL_OFFSET, 32'h0000_0003);
    wait_speed("jog one speed", 16'h0100);
    // the reported velocity trails the command through the motor and one register
    repeat (3) @(posedge sys_clk);
    check("tracking", {31'h0, trackingActive}, 32'h1);
    check("pos velocity", {16'h0000, posVelActual}, 32'h0000_0100);
    rdchk("state run", JMC_STATUS_OFFSET, 32'h0000_0009);
    wr(JMC_CTRL_OFFSET, 32'h0000_0001);
    repeat (4) @(posedge sys_clk);
    check("stop on release", {16'h0000, speedSetpoint}, 32'h0000_0000);
    check("irq masked", {31'h0, irq}, 32'h0);
    rdchk("stopped flag", JMC_IRQ_STATUS_OFFSET, 32'h0000_0008);
    wr(JMC_IRQ_MASK_OFFSET, 32'h0000_000F);
    repeat (2) @(posedge sys_clk);
    check("irq raised", {31'h0, irq}, 32'h1);
    wr(JMC_IRQ_STATUS_OFFSET, 32'h0000_000F);
    repeat (2) @(posedge sys_clk);
    check("irq cleared", {31'h0, irq}, 32'h0);
    wr(JMC_CTRL_OFFSET, 32'h0000_0003);
    wait_speed("restart same task", 16'h0100);
    wr(JMC_CTRL_OFFSET, 32'h0000_0001);
    jogPins.jogTwo <= 1'b1;
    wait_speed("jog two speed", 16'hFF00);
    jogPins.jogTwo <= 1'b0;
    repeat (6) @(posedge sys_clk);
    check("pin release stop", {16'h0000, speedSetpoint}, 32'h0000_0000);
    wr(JMC_CTRL_OFFSET, 32'h0000_0013);
    wait_speed("inverted speed", 16'hFF00);
    wr(JMC_CTRL_OFFSET, 32'h0000_0001);
    wr(JMC_IRQ_STATUS_OFFSET, 32'h0000_000F);
    wr(JMC_CTRL_OFFSET, 32'h0000_0007);
    repeat (6) @(posedge sys_clk);
    check("fault", {31'h0, jogFault}, 32'h1);
    check("fault speed", {16'h0000, speedSetpoint}, 32'h0000_0000);
    rdchk("fault flag", JMC_IRQ_STATUS_OFFSET, 32'h0000_0001);
    wr(JMC_CTRL_OFFSET, 32'h0000_0001);
    repeat (3) @(posedge sys_clk);
    check("fault gone", {31'h0, jogFault}, 32'h0);
    wr(JMC_CTRL_OFFSET, 32'h0000_0002);
    repeat (20) @(posedge sys_clk);
    check("no jog outside mode", {16'h0000, speedSetpoint}, 32'h0000_0000);
    wr(JMC_OVERRIDE_OFFSET, 32'h0000_0000);
    wr(JMC_CTRL_OFFSET, 32'h0000_0001);
    jogPins.jogOne <= 1'b1;
    repeat (20) @(posedge sys_clk);
    check("zero override", {16'h0000, speedSetpoint}, 32'h0000_0000);
    check("pin jog tracking", {31'h0, trackingActive}, 32'h1);
    jogPins.jogOne <= 1'b0;
    repeat (6) @(posedge sys_clk);
    check("pin jog released", {31'h0, trackingActive}, 32'h0);
    wr(JMC_OVERRIDE_OFFSET, 32'h0000_0080);
    wr(JMC_JOG_ONE_INCREMENT_OFFSET, 32'h0000_4000);
    wr(JMC_IRQ_STATUS_OFFSET, 32'h0000_000F);
    for (int i = 0; i < 2; i++) begin
      // the second pass starts a fresh increment from the new position and checks its done flag and its stop once more
      wr(JMC_CTRL_OFFSET, 32'h0000_000B);
      wait_irq(JMC_IRQ_INC_DONE);
      check("increment done", {31'h0, rd[JMC_IRQ_INC_DONE]}, 32'h1);
      wait_speed("increment stop", 16'h0000);
      wr(JMC_CTRL_OFFSET, 32'h0000_0009);
      wr(JMC_IRQ_STATUS_OFFSET, 32'h0000_000F);
    end
    wr(JMC_LIMIT_POS_OFFSET, actualPosition + 32'h0000_0400);
    wr(JMC_CTRL_OFFSET, 32'h0000_01C3);
    wait_irq(JMC_IRQ_LIMIT);
    check("limit reached", {31'h0, rd[JMC_IRQ_LIMIT]}, 32'h1);
    wait_speed("limit braked", 16'h0000);
    wr(JMC_CTRL_OFFSET, 32'h0000_0001);
    wr(JMC_IRQ_STATUS_OFFSET, 32'h0000_000F);
    wr(JMC_CTRL_OFFSET, 32'h0000_00C3);
    wait_speed("unreferenced runs", 16'h0100);
    rdchk("no limit flag", JMC_IRQ_STATUS_OFFSET, 32'h0000_0000);
    wr(JMC_CTRL_OFFSET, 32'h0000_0001);
    final_report();
  end
endmodule
